// ---- common/plc_defs.svh ----
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 25 MHz clock, word-wide register port
// Notes: included by bare name
`ifndef PLC_DEFS_SVH
`define PLC_DEFS_SVH

`define PLC_ADDR_W 5
`define PLC_DATA_W 16
`define PLC_ADDR_LINK 5'h0A
`define PLC_ADDR_EQ 5'h0B
`define PLC_LINK_RST 16'h0100
`define PLC_EQ_RST 16'h1000
`define PLC_EQ_WMASK 16'hF7FF

`define PLC_B_FASTPD 6
`define PLC_B_EXTFD 5
`define PLC_B_ENHLED 4
`define PLC_B_ISOL 3
`define PLC_B_RXERIDLE 2
`define PLC_B_ODDDIS 1
`define PLC_B_RMIICLK 0
`define PLC_B_EQBYP 12
`define PLC_B_DSCDROP 10
`define PLC_FLD_MSB 3

`define PLC_CLK_MHZ 25
`define PLC_BLINK_NS 50000000
`define PLC_BLINK_CYC (`PLC_BLINK_NS * `PLC_CLK_MHZ / 1000)
`define PLC_BLINK_W 21

`endif

// ---- common/plc_pkg.sv ----
// Purpose: types shared by the link option control block
// Assumes: all status inputs synchronous to the clock
// Notes: constants live in plc_defs.svh
package plc_pkg;

  // link state reported by the line-side logic
  typedef struct packed {
    logic linkUp;
    logic speed100;
    logic ieeeFull;
    logic localTx100;
    logic partnerForced100;
    logic activity;
  } plc_link_t;

  // transmit side from the MAC
  typedef struct packed {
    logic txEn;
    logic txEr;
  } plc_tx_t;

  // receive side events
  typedef struct packed {
    logic rxIdle;
    logic rxSymErr;
    logic eqErr;
    logic descrLoss;
    logic [3:0] fldEvent;
  } plc_rx_t;

endpackage

// ---- design/plc_top.sv ----
// Purpose: link option control registers and the logic they steer
// Assumes: inputs synchronous to clock, one clock domain
// Notes: read data valid only in the cycle after the read strobe
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "plc_defs.svh"

module plc_top #(
  parameter int BLINK_CYCLES = `PLC_BLINK_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [`PLC_ADDR_W-1:0] regAddr,
  input wire logic [`PLC_DATA_W-1:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [`PLC_DATA_W-1:0] regRdData,
  input wire logic xoverFastMode,
  input wire logic xoverRobustMode,
  input wire plc_pkg::plc_link_t linkSts,
  input wire plc_pkg::plc_tx_t txIn,
  input wire plc_pkg::plc_rx_t rxIn,
  input wire logic [1:0] rxdOnRxClk,
  input wire logic [1:0] rxdOnRefClk,
  output logic pdFastLinkUp,
  output logic fullDuplex,
  output logic ledLink,
  output logic miiIsolate,
  output logic rxSymErrFlag,
  output logic txEnOut,
  output logic txErOut,
  output logic rxRefIsRxClk,
  output logic [1:0] rxdOut,
  output logic eqErrOut,
  output logic linkDrop
);

  logic [`PLC_DATA_W-1:0] ctrlLink_reg;
  logic [`PLC_DATA_W-1:0] ctrlLink_next;
  logic [`PLC_DATA_W-1:0] ctrlEq_reg;
  logic [`PLC_DATA_W-1:0] ctrlEq_next;
  logic [`PLC_DATA_W-1:0] rdData_reg;
  logic [`PLC_BLINK_W-1:0] blinkCnt_reg;
  logic blinkPhase_reg;
  logic txEnPrev_reg;
  logic nibbleOdd_reg;
  logic pdFast_reg;
  logic fullDuplex_reg;
  logic led_reg;
  logic isolate_reg;
  logic rxErr_reg;
  logic txEn_reg;
  logic txEr_reg;
  logic refSel_reg;
  logic [1:0] rxd_reg;
  logic eqErr_reg;
  logic linkDrop_reg;

  // register decode
  wire selLink = (regAddr == `PLC_ADDR_LINK);
  wire selEq = (regAddr == `PLC_ADDR_EQ);
  wire wrLink = regWrStb & selLink;
  wire wrEq = regWrStb & selEq;
  wire [`PLC_DATA_W-1:0] rdMux = selLink ? ctrlLink_reg :
                                 selEq ? ctrlEq_reg : 16'h0000;

  // control fields
  wire xoverAuto = xoverFastMode | xoverRobustMode;
  wire fastPdEn = ctrlLink_reg[`PLC_B_FASTPD];
  wire extFdEn = ctrlLink_reg[`PLC_B_EXTFD];
  wire enhLedEn = ctrlLink_reg[`PLC_B_ENHLED];
  wire isolEn = ctrlLink_reg[`PLC_B_ISOL];
  wire rxErIdleEn = ctrlLink_reg[`PLC_B_RXERIDLE];
  wire oddDis = ctrlLink_reg[`PLC_B_ODDDIS];
  wire rmiiRxClkSel = ctrlLink_reg[`PLC_B_RMIICLK];
  wire eqBypass = ctrlEq_reg[`PLC_B_EQBYP];
  wire dscDropEn = ctrlEq_reg[`PLC_B_DSCDROP];
  wire [`PLC_FLD_MSB:0] fldModes = ctrlEq_reg[`PLC_FLD_MSB:0];

  // hardware set of the fast link-up bit wins over a software write
  wire [`PLC_DATA_W-1:0] linkWrVal = wrLink ? regWrData : ctrlLink_reg;
  wire [`PLC_DATA_W-1:0] linkSetMask =
    {{(`PLC_DATA_W-`PLC_B_FASTPD-1){1'b0}}, xoverAuto,
     {`PLC_B_FASTPD{1'b0}}};
  assign ctrlLink_next = linkWrVal | linkSetMask;
  assign ctrlEq_next = wrEq ? (regWrData & `PLC_EQ_WMASK) : ctrlEq_reg;

  // duplex decision
  wire extFdHit = extFdEn & linkSts.localTx100 & linkSts.partnerForced100;
  wire fdNext = extFdHit | linkSts.ieeeFull;

  // link LED
  wire fullTx100 = linkSts.linkUp & linkSts.speed100 & fdNext;
  wire blinkOff = linkSts.activity & blinkPhase_reg;
  wire ledNormal = linkSts.linkUp & ~blinkOff;
  wire ledNext = enhLedEn ? fullTx100 : ledNormal;

  // MAC-side isolation
  wire halfTx100 = linkSts.speed100 & ~fdNext;
  wire isolNext = isolEn & linkSts.linkUp &
                  (halfTx100 | ~linkSts.speed100);

  // receive symbol error during idle
  wire rxErrNext = rxIn.rxSymErr & (~rxIn.rxIdle | rxErIdleEn);

  // odd-nibble frame end
  wire txFall = ~txIn.txEn & txEnPrev_reg;
  wire oddEnd = txFall & nibbleOdd_reg & ~oddDis;
  wire txEnNext = txIn.txEn | oddEnd;
  wire txErNext = txIn.txEr | oddEnd;

  // RMII receive reference
  wire [1:0] rxdNext = rmiiRxClkSel ? rxdOnRxClk : rxdOnRefClk;

  // equalizer error and link drop
  wire eqErrNext = rxIn.eqErr & ~eqBypass;
  wire dscDrop = dscDropEn & rxIn.descrLoss;
  wire fldDrop = |(fldModes & rxIn.fldEvent);
  wire dropNext = dscDrop | fldDrop;

  // blink timer
  wire blinkWrap = (blinkCnt_reg == `PLC_BLINK_W'(BLINK_CYCLES - 1));
  wire [`PLC_BLINK_W-1:0] blinkCntNext =
    blinkWrap ? '0 : blinkCnt_reg + `PLC_BLINK_W'(1);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrlLink_reg <= `PLC_LINK_RST;
      ctrlEq_reg <= `PLC_EQ_RST;
      rdData_reg <= 16'h0000;
    end else begin
      ctrlLink_reg <= ctrlLink_next;
      ctrlEq_reg <= ctrlEq_next;
      rdData_reg <= regRdStb ? rdMux : 16'h0000;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      blinkCnt_reg <= '0;
      blinkPhase_reg <= 1'b0;
    end else begin
      blinkCnt_reg <= blinkCntNext;
      blinkPhase_reg <= blinkPhase_reg ^ blinkWrap;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      txEnPrev_reg <= 1'b0;
      nibbleOdd_reg <= 1'b0;
    end else begin
      txEnPrev_reg <= txIn.txEn;
      nibbleOdd_reg <= txIn.txEn & ~nibbleOdd_reg;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pdFast_reg <= 1'b0;
      fullDuplex_reg <= 1'b0;
      led_reg <= 1'b0;
      isolate_reg <= 1'b0;
      rxErr_reg <= 1'b0;
    end else begin
      pdFast_reg <= fastPdEn;
      fullDuplex_reg <= fdNext;
      led_reg <= ledNext;
      isolate_reg <= isolNext;
      rxErr_reg <= rxErrNext;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      txEn_reg <= 1'b0;
      txEr_reg <= 1'b0;
      refSel_reg <= 1'b0;
      rxd_reg <= 2'h0;
      eqErr_reg <= 1'b0;
      linkDrop_reg <= 1'b0;
    end else begin
      txEn_reg <= txEnNext;
      txEr_reg <= txErNext;
      refSel_reg <= rmiiRxClkSel;
      rxd_reg <= rxdNext;
      eqErr_reg <= eqErrNext;
      linkDrop_reg <= dropNext;
    end
  end

  assign regRdData = rdData_reg;
  assign pdFastLinkUp = pdFast_reg;
  assign fullDuplex = fullDuplex_reg;
  assign ledLink = led_reg;
  assign miiIsolate = isolate_reg;
  assign rxSymErrFlag = rxErr_reg;
  assign txEnOut = txEn_reg;
  assign txErOut = txEr_reg;
  assign rxRefIsRxClk = refSel_reg;
  assign rxdOut = rxd_reg;
  assign eqErrOut = eqErr_reg;
  assign linkDrop = linkDrop_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_fastpd_follow: assert property (
    rst_n |=> pdFastLinkUp == $past(ctrlLink_reg[`PLC_B_FASTPD])
  ) else $error("fast link-up output does not follow its bit");

  chk_xover_autoset: assert property (
    (rst_n && (xoverFastMode || xoverRobustMode)) |=>
    ctrlLink_reg[`PLC_B_FASTPD] ##1 pdFastLinkUp
  ) else $error("crossover mode did not set fast link-up");

  chk_extfd_full: assert property (
    (extFdEn && linkSts.localTx100 && linkSts.partnerForced100)
    |=> fullDuplex
  ) else $error("extended full duplex not applied");

  chk_ieee_duplex: assert property (
    (rst_n && !extFdEn) |=> fullDuplex == $past(linkSts.ieeeFull)
  ) else $error("duplex differs from standard decision");

  chk_enh_led: assert property (
    (enhLedEn && !(linkSts.linkUp && linkSts.speed100))
    |=> !ledLink
  ) else $error("enhanced LED lit without 100 link");

  chk_enh_noblink: assert property (
    (enhLedEn && linkSts.linkUp && linkSts.speed100 && fdNext)
    |=> ledLink
  ) else $error("enhanced LED not steady on full 100 link");

  chk_normal_led: assert property (
    (!enhLedEn && !linkSts.linkUp) |=> !ledLink
  ) else $error("LED lit without link");

  chk_mii_isolate: assert property (
    (isolEn && linkSts.linkUp && !linkSts.speed100) |=> miiIsolate
  ) else $error("MII not isolated on 10 link");

  chk_no_isolate: assert property (
    !isolEn |=> !miiIsolate
  ) else $error("MII isolated while isolation off");

  chk_idle_rxerr: assert property (
    (rxIn.rxIdle && rxIn.rxSymErr) |=> rxSymErrFlag == $past(rxErIdleEn)
  ) else $error("idle symbol error flag wrong");

  chk_odd_disable: assert property (
    (oddDis && !txIn.txEn && !txIn.txEr) |=> !txEnOut
  ) else $error("odd-nibble extension while disabled");

  chk_odd_extend: assert property (
    (txIn.txEn && !nibbleOdd_reg && !oddDis) ##1
    (!txIn.txEn && !oddDis) |=> txEnOut && txErOut
  ) else $error("odd-nibble end not extended as error");

  chk_rmii_refsel: assert property (
    rst_n |=> rxdOut == ($past(rmiiRxClkSel) ? $past(rxdOnRxClk)
                                             : $past(rxdOnRefClk))
  ) else $error("RMII receive data from wrong reference");

  chk_eq_bypass: assert property (
    eqBypass |=> !eqErrOut
  ) else $error("equalizer error passed while bypassed");

  chk_dsc_drop: assert property (
    (dscDropEn && rxIn.descrLoss) |=> linkDrop
  ) else $error("descrambler loss did not drop link");

  chk_fld_concur: assert property (
    ((fldModes & rxIn.fldEvent) != 4'h0) |=> linkDrop
  ) else $error("fast link down mode ignored");

  chk_write_effect: assert property (
    (wrEq && !regWrData[`PLC_B_EQBYP]) |=> !eqBypass
  ) else $error("written bit not in effect next cycle");

  chk_read_data: assert property (
    (rst_n && regRdStb && selEq) |=> regRdData == $past(ctrlEq_reg)
  ) else $error("read data wrong");

  chk_rxerr_busy: assert property (
    (rst_n && rxIn.rxSymErr && !rxIn.rxIdle) |=> rxSymErrFlag
  ) else $error("symbol error outside idle not flagged");

  chk_even_end: assert property (
    (rst_n && txFall && !nibbleOdd_reg && !txIn.txEr)
    |=> !txEnOut && !txErOut
  ) else $error("even-length frame extended");

  chk_odd_single: assert property (
    (rst_n && oddEnd) ##1 (!txIn.txEn && !txIn.txEr)
    |=> !txEnOut && !txErOut
  ) else $error("odd-nibble extension longer than one cycle");

  chk_normal_led_on: assert property (
    (rst_n && !enhLedEn && linkSts.linkUp && !linkSts.activity)
    |=> ledLink
  ) else $error("LED dark on established link");

  chk_isolate_full100: assert property (
    (isolEn && linkSts.speed100 && fdNext) |=> !miiIsolate
  ) else $error("MII isolated on full duplex 100 link");

  chk_eq_pass: assert property (
    (rst_n && !eqBypass && rxIn.eqErr) |=> eqErrOut
  ) else $error("equalizer error lost while not bypassed");

  chk_drop_quiet: assert property (
    (!(dscDropEn && rxIn.descrLoss) && ((fldModes & rxIn.fldEvent) == 4'h0))
    |=> !linkDrop
  ) else $error("link dropped without cause");

  chk_unmapped_read: assert property (
    (rst_n && regRdStb && !selLink && !selEq) |=> regRdData == 16'h0000
  ) else $error("unmapped read not zero");

  chk_read_idle: assert property (
    !regRdStb |=> regRdData == 16'h0000
  ) else $error("read data stands past its cycle");

  chk_link_write: assert property (
    (rst_n && wrLink && !xoverAuto) |=> ctrlLink_reg == $past(regWrData)
  ) else $error("link register write not in effect");

  cov_autoset: cover property (
    !ctrlLink_reg[`PLC_B_FASTPD] ##1 ctrlLink_reg[`PLC_B_FASTPD]
  );
  cov_odd_extend: cover property (oddEnd ##1 txErOut);
  cov_dsc_drop: cover property (dscDrop ##1 linkDrop);
  cov_enh_led: cover property (enhLedEn && ledLink);
  cov_isolate: cover property (rst_n && miiIsolate);

endmodule // plc_top

`default_nettype wire

// ---- tb/plc_mac_model.sv ----
// Purpose: MAC transmit side, frames of a chosen nibble count
// Assumes: one nibble per clock, frame starts on go
// Notes: txEr stays low, txEn low between frames
`timescale 1ns/1ps
`default_nettype none
module plc_mac_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [3:0] nibbles,
  output var plc_pkg::plc_tx_t tx
);
  logic [3:0] nibLeft_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) nibLeft_reg <= 4'h0;
    else if (go) nibLeft_reg <= nibbles;
    else if (nibLeft_reg != 4'h0) nibLeft_reg <= nibLeft_reg - 4'h1;
  end
  // frame length sets the nibble parity
  assign tx = {nibLeft_reg != 4'h0, 1'b0};
endmodule // plc_mac_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for the link option controls
// Assumes: 25 MHz clock, blink period shortened to 4 cycles
// Notes: register checks first, then table of link cases, then hand-written cases
`timescale 1ns/1ps
`default_nettype none
`include "plc_defs.svh"
`define TB_CHK(g, e) begin \
  numChecks++; \
  if ((g) !== (e)) begin \
    errTotal++; \
    $display("Error t=%0t got %h exp %h", $time, g, e); \
  end \
end
module testbench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] regAddr = 5'h00;
  logic [15:0] regWrData = 16'h0000;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic [15:0] regRdData;
  logic xoverFastMode = 1'b0;
  logic xoverRobustMode = 1'b0;
  plc_pkg::plc_link_t linkSts = '0;
  plc_pkg::plc_tx_t txIn;
  plc_pkg::plc_rx_t rxIn = '0;
  logic go = 1'b0;
  logic [3:0] nibbles = 4'h0;
  logic pdFastLinkUp, fullDuplex, ledLink, miiIsolate, rxSymErrFlag;
  logic txEnOut, txErOut, rxRefIsRxClk, eqErrOut, linkDrop;
  logic [1:0] rxdOut;
  logic [15:0] rdVal;
  logic [1:0] rxdRx = 2'h1;
  logic [1:0] rxdRef = 2'h2;
  logic [4:0] outs;
  int errTotal = 0;
  int numChecks = 0;
  int cycles = 0;
  int enHi, erHi, ledLo;
  // reg bits 6:0, link status, {pdFast, fullDup, led, isolate, rxRef}
  logic [17:0] rows [10] = '{
    {7'h00, 6'h38, 5'h0C}, {7'h00, 6'h36, 5'h04}, {7'h20, 6'h36, 5'h0C},
    {7'h10, 6'h30, 5'h00}, {7'h10, 6'h38, 5'h0C}, {7'h08, 6'h30, 5'h06},
    {7'h08, 6'h28, 5'h0E}, {7'h08, 6'h38, 5'h0C}, {7'h08, 6'h00, 5'h00},
    {7'h41, 6'h38, 5'h1D}};
  always #20 clock = ~clock;
  plc_top #(.BLINK_CYCLES(4)) u_dut (.clock(clock), .rst_n(rst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .regRdData(regRdData),
    .xoverFastMode(xoverFastMode), .xoverRobustMode(xoverRobustMode),
    .linkSts(linkSts), .txIn(txIn), .rxIn(rxIn),
    .rxdOnRxClk(rxdRx), .rxdOnRefClk(rxdRef), .pdFastLinkUp(pdFastLinkUp),
    .fullDuplex(fullDuplex), .ledLink(ledLink), .miiIsolate(miiIsolate),
    .rxSymErrFlag(rxSymErrFlag), .txEnOut(txEnOut), .txErOut(txErOut),
    .rxRefIsRxClk(rxRefIsRxClk), .rxdOut(rxdOut), .eqErrOut(eqErrOut),
    .linkDrop(linkDrop));
  plc_mac_model u_mac (.clock(clock), .rst_n(rst_n), .go(go),
    .nibbles(nibbles), .tx(txIn));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clock);
    regWrStb <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clock);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clock);
    regRdStb <= 1'b0;
    #1 d = regRdData;
  endtask
  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic watch(input int n);
    enHi = 0;
    erHi = 0;
    ledLo = 0;
    repeat (n) begin
      @(posedge clock);
      #1;
      enHi += int'(txEnOut === 1'b1);
      erHi += int'(txErOut === 1'b1);
      ledLo += int'(ledLink === 1'b0);
    end
  endtask
  task automatic send(input logic [3:0] n);
    @(posedge clock);
    go <= 1'b1;
    nibbles <= n;
    @(posedge clock);
    go <= 1'b0;
    watch(8);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      errTotal++;
      stop_test();
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    rd(`PLC_ADDR_LINK, rdVal);
    `TB_CHK(rdVal, 16'h0100)
    rd(`PLC_ADDR_EQ, rdVal);
    `TB_CHK(rdVal, 16'h1000)
    rd(5'h05, rdVal);
    `TB_CHK(rdVal, 16'h0000)
    wr(`PLC_ADDR_EQ, 16'hFFFF);
    rd(`PLC_ADDR_EQ, rdVal);
    `TB_CHK(rdVal, 16'hF7FF)
    wr(`PLC_ADDR_EQ, 16'h1000);
    $display("test registers done");
    for (int i = 0; i < 10; i++) begin
      wr(`PLC_ADDR_LINK, {9'h000, rows[i][17:11]});
      linkSts <= rows[i][10:5];
      rxdRx <= 2'(i);
      rxdRef <= ~2'(i);
      settle();
      outs = {pdFastLinkUp, fullDuplex, ledLink, miiIsolate, rxRefIsRxClk};
      `TB_CHK(outs, rows[i][4:0])
      `TB_CHK(rxdOut, (rows[i][11] ? 2'(i) : ~2'(i)))
    end
    $display("test table done");
    @(posedge clock);
    xoverFastMode <= 1'b1;
    wr(`PLC_ADDR_LINK, 16'h0000);
    settle();
    `TB_CHK(pdFastLinkUp, 1'b1)
    @(posedge clock);
    xoverFastMode <= 1'b0;
    xoverRobustMode <= 1'b1;
    wr(`PLC_ADDR_LINK, 16'h0000);
    rd(`PLC_ADDR_LINK, rdVal);
    `TB_CHK(rdVal[6], 1'b1)
    @(posedge clock);
    xoverRobustMode <= 1'b0;
    wr(`PLC_ADDR_LINK, 16'h0000);
    settle();
    `TB_CHK(pdFastLinkUp, 1'b0)
    $display("test crossover done");
    @(posedge clock);
    linkSts <= 6'h39;
    watch(16);
    `TB_CHK(ledLo != 0, 1'b1)
    wr(`PLC_ADDR_LINK, 16'h0010);
    settle();
    watch(16);
    `TB_CHK(ledLo, 0)
    $display("test led done");
    @(posedge clock);
    rxIn <= 8'hC0;
    wr(`PLC_ADDR_LINK, 16'h0000);
    settle();
    `TB_CHK(rxSymErrFlag, 1'b0)
    wr(`PLC_ADDR_LINK, 16'h0004);
    settle();
    `TB_CHK(rxSymErrFlag, 1'b1)
    @(posedge clock);
    rxIn <= 8'h40;
    wr(`PLC_ADDR_LINK, 16'h0000);
    settle();
    `TB_CHK(rxSymErrFlag, 1'b1)
    @(posedge clock);
    rxIn <= 8'h00;
    wr(`PLC_ADDR_LINK, 16'h0000);
    send(4'h1);
    `TB_CHK({enHi, erHi}, {32'd2, 32'd1})
    send(4'h2);
    `TB_CHK({enHi, erHi}, {32'd2, 32'd0})
    wr(`PLC_ADDR_LINK, 16'h0002);
    send(4'h1);
    `TB_CHK({enHi, erHi}, {32'd1, 32'd0})
    $display("test transmit done");
    @(posedge clock);
    rxIn <= 8'h30;
    settle();
    `TB_CHK(eqErrOut, 1'b0)
    `TB_CHK(linkDrop, 1'b0)
    wr(`PLC_ADDR_EQ, 16'h0400);
    settle();
    `TB_CHK({eqErrOut, linkDrop}, 2'h3)
    @(posedge clock);
    rxIn <= 8'h01;
    wr(`PLC_ADDR_EQ, 16'h0401);
    settle();
    `TB_CHK(linkDrop, 1'b1)
    $display("test receive done");
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    `TB_CHK({pdFastLinkUp, fullDuplex, ledLink, linkDrop}, 4'h0)
    @(posedge clock);
    rst_n <= 1'b1;
    rd(`PLC_ADDR_LINK, rdVal);
    `TB_CHK(rdVal, 16'h0100)
    rd(`PLC_ADDR_EQ, rdVal);
    `TB_CHK(rdVal, 16'h1000)
    `TB_CHK({fullDuplex, linkDrop}, 2'h2)
    $display("test reset done");
    stop_test();
  end
endmodule // testbench
`default_nettype wire
